// ---- src/trb_pkg.sv ----
// Constants for the limit and result register bank of the field sensor.
// Function
// - Magnetic limit word: signed upper limit high byte, signed lower low.
// - One limit code equals axis range over 128; compare scales with range.
// - Magnetic upper limits reset to 7Dh, lower limits to 83h.
// - Axis-3 limits at 6h reset 7D83h; temperature limits at 7h reset 6732h.
// - Temperature limits are signed codes of 4.267 degC per step.
// - Temperature upper limit resets to 67h, lower limit to 32h.
// - Status bit 13 shows valid buffered conversion data.
// - Status bit 12 shows angle and magnitude data are current.
// - Status bit 11 shows temperature data is current.
// - Status bits 10..8 show axis 3, 2, 1 data are current.
// - Status bits 6..4 count completed data sets, wrapping.
// - Status bits 1..0 encode alert cause: none, frontend, system, both.
// - Conversion status is read-only at 8h, resets zero except live cause bits 1..0, reserved reads zero.
// - Axis results are read-only at 9h, Ah, Bh, resetting to zero.
// - Temperature result is read-only at Ch, resetting to zero.
// - Alert raised only after 1 to 4 consecutive out-of-limit conversions.
// - Latched alert holds until software reads status or result registers.
`default_nettype none

package trb_pkg;
    localparam logic [3:0]  ADDR_AXIS2_LIMITS   = 4'h5;
    localparam logic [3:0]  ADDR_AXIS3_LIMITS   = 4'h6;
    localparam logic [3:0]  ADDR_TEMP_LIMITS    = 4'h7;
    localparam logic [3:0]  ADDR_CONV_STATE     = 4'h8;
    localparam logic [3:0]  ADDR_AXIS1_RESULT   = 4'h9;
    localparam logic [3:0]  ADDR_AXIS2_RESULT   = 4'ha;
    localparam logic [3:0]  ADDR_AXIS3_RESULT   = 4'hb;
    localparam logic [3:0]  ADDR_TEMP_RESULT    = 4'hc;
    localparam logic [15:0] RST_MAG_LIMITS      = 16'h7d83;
    localparam logic [15:0] RST_TEMP_LIMITS     = 16'h6732;
    localparam int          UPPER_MSB           = 15;
    localparam int          UPPER_LSB           = 8;
    localparam int          LOWER_MSB           = 7;
    localparam int          LOWER_LSB           = 0;
    localparam int          RANGE_CODE_STEPS    = 128;
    localparam int          ST_READY_BIT        = 13;
    localparam int          ST_ANGLE_BIT        = 12;
    localparam int          ST_TEMP_BIT         = 11;
    localparam int          ST_AXIS_LSB         = 8;
    localparam int          ST_COUNT_LSB        = 4;
    localparam int          ST_CAUSE_LSB        = 0;
    localparam logic [1:0]  CAUSE_NONE          = 2'h0;
    localparam logic [1:0]  CAUSE_FRONTEND      = 2'h1;
    localparam logic [1:0]  CAUSE_SYSTEM        = 2'h2;
    localparam logic [1:0]  CAUSE_BOTH          = 2'h3;
    localparam int          MAX_REPEAT          = 4;
endpackage : trb_pkg

`default_nettype wire

// ---- src/trb_bank.sv ----
// Limit registers, conversion status and result registers with alert logic.
`default_nettype none

module trb_bank
    import trb_pkg::*;
#(
    parameter int RESULT_W = 16
) (
    input  wire logic                i_core_clk,
    input  wire logic                i_nrst,
    input  wire logic                i_clk_en,
    input  wire logic                i_wr_en,
    input  wire logic                i_rd_en,
    input  wire logic [3:0]          i_addr,
    input  wire logic [15:0]         i_wr_data,
    output var  logic [15:0]         o_rd_data,
    output logic                     o_addr_hit,
    input  wire logic                i_set_done,
    input  wire logic [RESULT_W-1:0] i_axis1_data,
    input  wire logic [RESULT_W-1:0] i_axis2_data,
    input  wire logic [RESULT_W-1:0] i_axis3_data,
    input  wire logic [RESULT_W-1:0] i_temp_data,
    input  wire logic [2:0]          i_axis_current,
    input  wire logic                i_angle_current,
    input  wire logic                i_temp_current,
    input  wire logic                i_conv_start,
    input  wire logic [15:0]         i_axis1_limits,
    input  wire logic [1:0]          i_axis_range_shift,
    input  wire logic [3:0]          i_limit_alert_en,
    input  wire logic [1:0]          i_crossing_repeat_count,
    input  wire logic                i_alert_latched_mode,
    input  wire logic                i_frontend_fault_flags,
    input  wire logic                i_system_fault_flags,
    output var  logic                o_limit_alert
);

    ////////////////////////////////////////////////////////////////////////
    // Reset synchroniser: async assert, release through two flops.
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers.
    logic [15:0] axis2_limits;
    logic [15:0] axis3_limits;
    logic [15:0] temperature_limits;
    logic [15:0] axis1_result;
    logic [15:0] axis2_result;
    logic [15:0] axis3_result;
    logic [15:0] temperature_result;
    logic        data_ready;
    logic        angle_cur;
    logic        temp_cur;
    logic [2:0]  axis_cur;
    logic [2:0]  set_count;
    logic [1:0]  repeat_cnt [4];
    logic        alert_hold;

    // Sign-extend a result to 16 bits for storage and comparison.
    function automatic logic [15:0] widen(input logic [RESULT_W-1:0] v);
        logic [15:0] r;
        r = 16'(signed'(v));
        return r;
    endfunction : widen

    // True when the result lies strictly above the upper or below the lower
    // limit. The top byte of the result is the code in units of range/128
    // for the base range; a wider range shift scales the code down, so the
    // same limit code follows the axis's range setting.
    function automatic logic beyond(input logic [15:0] res,
                                    input logic [15:0] lim,
                                    input logic [1:0]  shift);
        logic signed [15:0] code;
        logic signed [15:0] up;
        logic signed [15:0] lo;
        code = signed'(res) >>> (UPPER_LSB + 32'(shift) - 1 + 1);
        up   = 16'(signed'(lim[UPPER_MSB:UPPER_LSB]));
        lo   = 16'(signed'(lim[LOWER_MSB:LOWER_LSB]));
        return (code > up) || (code < lo);
    endfunction : beyond

    ////////////////////////////////////////////////////////////////////////
    // Address decode and side effects of access.
    wire acc_on      = i_clk_en && rst_n;
    wire wr_axis2    = acc_on && i_wr_en && (i_addr == ADDR_AXIS2_LIMITS);
    wire wr_axis3    = acc_on && i_wr_en && (i_addr == ADDR_AXIS3_LIMITS);
    wire wr_temp     = acc_on && i_wr_en && (i_addr == ADDR_TEMP_LIMITS);
    wire rd_clears   = acc_on && i_rd_en && (i_addr >= ADDR_CONV_STATE)
                       && (i_addr <= ADDR_TEMP_RESULT);
    wire set_take    = acc_on && i_set_done;
    wire conv_take   = acc_on && i_conv_start;

    // Alert cause code from the two outside fault summaries.
    wire [1:0] alert_cause = {i_system_fault_flags, i_frontend_fault_flags};

    wire [15:0] conv_state = {2'h0, data_ready, angle_cur, temp_cur,
                              axis_cur, 1'b0, set_count, 2'h0, alert_cause};

    assign o_addr_hit = (i_addr >= ADDR_AXIS2_LIMITS)
                        && (i_addr <= ADDR_TEMP_RESULT);

    // Writable limit registers; reads have no effect on them.
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            axis2_limits       <= RST_MAG_LIMITS;
            axis3_limits       <= RST_MAG_LIMITS;
            temperature_limits <= RST_TEMP_LIMITS;
        end else begin
            if (wr_axis2) axis2_limits       <= i_wr_data;
            if (wr_axis3) axis3_limits       <= i_wr_data;
            if (wr_temp)  temperature_limits <= i_wr_data;
        end
    end

    // Results and their flags load as one set, so a read never mixes them.
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            axis1_result       <= 16'h0000;
            axis2_result       <= 16'h0000;
            axis3_result       <= 16'h0000;
            temperature_result <= 16'h0000;
            axis_cur           <= 3'h0;
            angle_cur          <= 1'b0;
            temp_cur           <= 1'b0;
            set_count          <= 3'h0;
        end else if (set_take) begin
            axis1_result       <= widen(i_axis1_data);
            axis2_result       <= widen(i_axis2_data);
            axis3_result       <= widen(i_axis3_data);
            temperature_result <= widen(i_temp_data);
            axis_cur           <= i_axis_current;
            angle_cur          <= i_angle_current;
            temp_cur           <= i_temp_current;
            set_count          <= set_count + 3'h1;
        end
    end

    // Ready drops when a new conversion starts; completion wins over it.
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_ready <= 1'b0;
        end else if (set_take) begin
            data_ready <= 1'b1;
        end else if (conv_take) begin
            data_ready <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Limit crossing: per channel run counter of out-of-limit sets.
    // Channel 0 uses the axis-1 limits that live outside this bank.
    logic [3:0] crossed;
    assign crossed[0] = beyond(widen(i_axis1_data), i_axis1_limits,
                               i_axis_range_shift);
    assign crossed[1] = beyond(widen(i_axis2_data), axis2_limits,
                               i_axis_range_shift);
    assign crossed[2] = beyond(widen(i_axis3_data), axis3_limits,
                               i_axis_range_shift);
    assign crossed[3] = beyond(widen(i_temp_data), temperature_limits,
                               2'h0);

    logic [3:0] run_met;
    always_comb begin
        for (int k = 0; k < MAX_REPEAT; k++) begin
            run_met[k] = i_limit_alert_en[k] && crossed[k]
                         && (repeat_cnt[k] >= i_crossing_repeat_count);
        end
    end

    // Counters saturate at the chosen run length and restart on a good set.
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < MAX_REPEAT; k++) repeat_cnt[k] <= 2'h0;
        end else if (set_take) begin
            for (int k = 0; k < MAX_REPEAT; k++) begin
                if (!crossed[k]) begin
                    repeat_cnt[k] <= 2'h0;
                end else if (repeat_cnt[k] < i_crossing_repeat_count) begin
                    repeat_cnt[k] <= repeat_cnt[k] + 2'h1;
                end
            end
        end
    end

    wire alert_now = set_take && (|run_met);

    // Live mode follows each set; latched mode holds until a status or result read.
    // A new crossing in the clearing cycle keeps the alert set.
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_hold <= 1'b0;
        end else if (alert_now) begin
            alert_hold <= 1'b1;
        end else if (i_alert_latched_mode) begin
            if (rd_clears) alert_hold <= 1'b0;
        end else if (set_take) begin
            alert_hold <= 1'b0;
        end
    end

    assign o_limit_alert = alert_hold;

    ////////////////////////////////////////////////////////////////////////
    // Read data register; unmapped offsets read zero.
    logic [15:0] next_rd_data;
    always_comb begin
        case (i_addr)
            ADDR_AXIS2_LIMITS: next_rd_data = axis2_limits;
            ADDR_AXIS3_LIMITS: next_rd_data = axis3_limits;
            ADDR_TEMP_LIMITS:  next_rd_data = temperature_limits;
            ADDR_CONV_STATE:   next_rd_data = conv_state;
            ADDR_AXIS1_RESULT: next_rd_data = axis1_result;
            ADDR_AXIS2_RESULT: next_rd_data = axis2_result;
            ADDR_AXIS3_RESULT: next_rd_data = axis3_result;
            ADDR_TEMP_RESULT:  next_rd_data = temperature_result;
            default:           next_rd_data = 16'h0000;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rd_data <= 16'h0000;
        end else if (acc_on && i_rd_en) begin
            o_rd_data <= next_rd_data;
        end
    end

endmodule : trb_bank

`default_nettype wire

// ---- tb/trb_bank_monitor.sv ----
// Port checker for the limit and result register bank.
`default_nettype none
module trb_bank_monitor #(
    parameter int RESULT_W = 16
) (
    input wire logic                i_core_clk,
    input wire logic                i_nrst,
    input wire logic                i_clk_en,
    input wire logic                i_rd_en,
    input wire logic [3:0]          i_addr,
    input wire logic [15:0]         o_rd_data,
    input wire logic                o_addr_hit,
    input wire logic                i_set_done,
    input wire logic [RESULT_W-1:0] i_axis1_data,
    input wire logic [2:0]          i_axis_current,
    input wire logic                i_angle_current,
    input wire logic                i_temp_current,
    input wire logic                i_conv_start,
    input wire logic                i_alert_latched_mode,
    input wire logic                i_frontend_fault_flags,
    input wire logic                i_system_fault_flags,
    input wire logic                o_limit_alert
);
    timeunit 1ns;
    timeprecision 1ps;
    // Taken reads and completions; a same-cycle set makes a read ambiguous.
    wire logic rd   = i_rd_en && i_clk_en && !i_set_done;
    wire logic st   = rd && i_addr == 4'h8;
    wire logic done = i_set_done && i_clk_en;
    wire logic clr  = rd && i_addr >= 4'h8 && i_addr <= 4'hc;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    ////////////////////////////////////////////////////////////////
    property p_unmapped; rd && !o_addr_hit |=> o_rd_data == 16'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("bad empty read");
    property p_resvd; st |=> (o_rd_data & 16'hc08c) == 16'h0; endproperty
    a_resvd: assert property (p_resvd) else $error("reserved bits set");
    property p_cause; st |=> o_rd_data[1:0] ==
        $past({i_system_fault_flags, i_frontend_fault_flags}); endproperty
    a_cause: assert property (p_cause) else $error("cause wrong");
    property p_flags; done ##1 st && !i_conv_start |=> o_rd_data[13:8] ==
        {1'b1, $past({i_angle_current, i_temp_current, i_axis_current}, 2)};
    endproperty
    a_flags: assert property (p_flags) else $error("flags wrong");
    property p_unready; i_conv_start && !done ##1 st |=> !o_rd_data[13];
    endproperty
    a_unready: assert property (p_unready) else $error("ready kept");
    property p_result; done ##1 rd && i_addr == 4'h9 |=>
        o_rd_data == 16'($past(i_axis1_data, 2)); endproperty
    a_result: assert property (p_result) else $error("result wrong");
    property p_rise; $rose(o_limit_alert) |-> $past(done); endproperty
    a_rise: assert property (p_rise) else $error("alert without set");
    property p_hold; o_limit_alert && i_alert_latched_mode && !clr &&
        !i_set_done |=> o_limit_alert; endproperty
    a_hold: assert property (p_hold) else $error("latch lost");
    property p_clear; o_limit_alert && i_alert_latched_mode && clr |=>
        !o_limit_alert; endproperty
    a_clear: assert property (p_clear) else $error("latch kept");
    c_alert: cover property ($rose(o_limit_alert));
    c_set: cover property (done ##1 st);
    c_clear: cover property (o_limit_alert && clr);
endmodule : trb_bank_monitor
bind trb_bank trb_bank_monitor #(.RESULT_W(RESULT_W)) u_mon (.*);
`default_nettype wire

// ---- tb/trb_engine_model.sv ----
// Behavioural measurement engine that feeds data sets to the bank.
`default_nettype none
module trb_engine_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_fire,
    input  wire logic [15:0] i_seed,
    output var  logic        o_conv_start,
    output var  logic        o_set_done,
    output logic [63:0]      o_data,
    output logic [4:0]       o_flags
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  cnt;
    logic [15:0] val;
    // Lines are only valid with the pulse; idle they show the inverse.
    wire logic [63:0] set_w = {val + 16'h3, val + 16'h2, val + 16'h1, val};
    assign o_data  = o_set_done ? set_w : ~set_w;
    assign o_flags = o_set_done ? val[4:0] : ~val[4:0];
    // A fire request starts a conversion that completes six cycles later.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt          <= 4'h0;
            val          <= 16'h0;
            o_conv_start <= 1'b0;
            o_set_done   <= 1'b0;
        end else begin
            o_conv_start <= i_fire;
            o_set_done   <= cnt == 4'h1;
            cnt          <= i_fire ? 4'h6 : cnt - 4'(cnt != 4'h0);
            val          <= i_fire ? i_seed : val;
        end
    end
endmodule : trb_engine_model
`default_nettype wire

// ---- tb/trb_bank_test.sv ----
// Self-checking bench of the limit and result register bank.
`default_nettype none
module trb_bank_test
    import trb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        fire = 1'b0, latch = 1'b0, fe = 1'b0, sy = 1'b0;
    logic [3:0]  addr = 4'h0, en = 4'h0;
    logic [1:0]  rep = 2'h0, sh = 2'h0;
    logic        ce = 1'b1;
    logic [15:0] wd = 16'h0, seed = 16'h0, rdat;
    logic        hit, alert, cs, sd;
    logic [4:0]  flg;
    logic [63:0] dat;
    int          failures = 0, num_checks = 0;
    always #5 clk = ~clk;
    trb_bank uut (
        .i_core_clk(clk), .i_nrst(nrst), .i_clk_en(ce), .i_wr_en(wr),
        .i_rd_en(rd), .i_addr(addr), .i_wr_data(wd), .o_rd_data(rdat),
        .o_addr_hit(hit), .i_set_done(sd), .i_axis1_data(dat[15:0]),
        .i_axis2_data(dat[31:16]), .i_axis3_data(dat[47:32]),
        .i_temp_data(dat[63:48]), .i_axis_current(flg[2:0]),
        .i_angle_current(flg[3]), .i_temp_current(flg[4]),
        .i_conv_start(cs), .i_axis1_limits(16'h7d83),
        .i_axis_range_shift(sh), .i_limit_alert_en(en),
        .i_crossing_repeat_count(rep), .i_alert_latched_mode(latch),
        .i_frontend_fault_flags(fe), .i_system_fault_flags(sy),
        .o_limit_alert(alert));
    trb_engine_model u_eng (
        .i_core_clk(clk), .i_nrst(nrst), .i_fire(fire), .i_seed(seed),
        .o_conv_start(cs), .o_set_done(sd), .o_data(dat), .o_flags(flg));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrt(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        {wr, addr, wd} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrt
    // Read one word; the answer is registered, so sample after the edge.
    task automatic rdc(input logic [3:0] a, input logic [15:0] e,
                       input logic [15:0] m = 16'hffff);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk({15'h0, hit}, {15'h0, (a inside {[4'h5:4'hc]})});
        chk(rdat & m, e & m);
    endtask : rdc
    task automatic ack(input logic e);
        @(posedge clk);
        #1;
        chk({15'h0, alert}, {15'h0, e});
    endtask : ack
    // Fire one data set; optionally peek at the status while it converts.
    task automatic go(input logic [15:0] v, input logic [1:0] f,
                      input logic q);
        int n;
        @(posedge clk);
        {fire, seed, sy, fe} <= {1'b1, v, f};
        @(posedge clk);
        fire <= 1'b0;
        if (q) rdc(ADDR_CONV_STATE, 16'h0, 16'h2000);
        for (n = 0; n < 20 && sd !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 20) begin
            failures++;
            stop_test();
        end
    endtask : go
    function automatic logic [15:0] expw(input logic [3:0] a,
            input logic [15:0] v, input logic [2:0] c, input logic [1:0] f);
        return a == 4'h8 ? {3'h1, v[3], v[4], v[2:0], 1'b0, c, 2'h0, f}
                         : v + 16'(a - 4'h9);
    endfunction : expw
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] v;
        logic [3:0]  a;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 16; i++) begin
            a = 4'(i);
            rdc(a, a == 4'h7 ? 16'h6732 : (a inside {4'h5, 4'h6}) ?
                16'h7d83 : 16'h0);
        end
        $display("test reset values done");
        // Limits keep what is written; status and results refuse writes.
        for (int i = 5; i < 13; i++) wrt(4'(i), 16'h9c00 | 16'(i));
        for (int i = 5; i < 13; i++)
            rdc(4'(i), i < 8 ? 16'h9c00 | 16'(i) : 16'h0);
        // A write with the clock enable low must leave the limits alone.
        @(posedge clk);
        ce <= 1'b0;
        wrt(ADDR_AXIS2_LIMITS, 16'h1234);
        ce <= 1'b1;
        rdc(ADDR_AXIS2_LIMITS, 16'h9c05);
        $display("test write access done");
        // Eight sets walk the counter round; read order rotates per set.
        for (int k = 0; k < 8; k++) begin
            v = 16'h2461 * 16'(k + 1);
            go(v, 2'(k), k == 7);
            for (int j = 0; j < 5; j++) begin
                a = 4'(8 + (j + k) % 5);
                rdc(a, expw(a, v, 3'(k + 1), 2'(k)));
            end
        end
        $display("test data sets done");
        wrt(ADDR_AXIS3_LIMITS, 16'h1083);
        {en, rep, latch} <= {4'h4, 2'h1, 1'b1};
        go(16'h3ffe, 2'h0, 1'b0);
        ack(1'b0);
        go(16'h3ffe, 2'h0, 1'b0);
        ack(1'b1);
        rdc(ADDR_AXIS2_LIMITS, 16'h9c05);
        ack(1'b1);
        rdc(ADDR_AXIS1_RESULT, 16'h3ffe);
        ack(1'b0);
        @(posedge clk);
        latch <= 1'b0;
        // Live mode: one in-limit set drops the alert again.
        for (int i = 0; i < 4; i++) begin
            go((i == 1 || i == 2) ? 16'h3ffe : 16'h0, 2'h0, 1'b0);
            ack(i == 2);
        end
        // A wider range shift scales the code so the same run stays inside.
        @(posedge clk);
        sh <= 2'h2;
        for (int i = 0; i < 2; i++) begin
            go(16'h3ffe, 2'h0, 1'b0);
            ack(1'b0);
        end
        $display("test alert done");
        stop_test();
    end
endmodule : trb_bank_test
`default_nettype wire
